/* gyod_output_regs.sv */
// Gyro output data page: page selector, read-only rate words, read port
//
// How it works
// - Page selector resets to zero, so page 0 is active after start-up.
// - Page 0 carries the output data registers, here the gyro words.
// - Each gyro result is a 32-bit two's complement value in two words.
// - High register holds bits 31:16, low register holds bits 15:0.
// - High word: 0.02 deg/s per count, zero at rest, +-450 deg/s range.
// - Low word MSB weighs 0.01 deg/s, each lower bit half the one above.
// - Gyro low/high words at 0x10/0x12, 0x14/0x16, 0x18/0x1A on page 0.
// - Output data registers are read-only; writes to them change nothing.
`timescale 1ns/1ps
module gyod_output_regs (
	input wire logic clk,
	input wire logic reset,
	input gyod_pkg::gyod_req_t req,
	input gyod_pkg::gyod_sample_t sample,
	output gyod_pkg::gyod_rsp_t rsp,
	output logic [gyod_pkg::PAGE_W-1:0] activePage,
	output logic sampleSeen
);
	import gyod_pkg::*;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_READ,
		ST_ANSWER
	} gyod_state_t;

	gyod_state_t state_r;
	gyod_state_t state_nxt;
	logic [PAGE_W-1:0] pageSel_r;
	logic [PAGE_W-1:0] pageSel_nxt;
	logic [1:0] rdAxis_r;
	logic [1:0] rdAxis_nxt;
	logic rdHigh_r;
	logic rdHigh_nxt;
	logic pageRead_r;
	logic pageRead_nxt;
	logic gyroHit_r;
	logic gyroHit_nxt;
	logic rspValid_r;
	logic rspValid_nxt;
	logic [WORD_W-1:0] rspData_r;
	logic [WORD_W-1:0] rspData_nxt;
	logic sampleSeen_r;
	logic sampleSeen_nxt;
	logic idle;
	logic readTake;
	logic writeTake;
	logic pageHit;
	logic gyroHit;
	logic [1:0] decAxis;
	logic decHigh;
	logic [ADDR_W-1:0] relAddr;
	logic [WORD_W-1:0] storeData;

	////////////////////////////////////////////////////////////////////////
	// Request acceptance: nothing is taken while a read is in flight
	// Writes complete at the take and give no answer
	always_comb begin
		idle = (state_r == ST_IDLE);
		readTake = idle && req.valid && !req.write;
		writeTake = idle && req.valid && req.write;
	end

	////////////////////////////////////////////////////////////////////////
	// Address decode of the gyro words on the output data page
	always_comb begin
		relAddr = req.addr - ADDR_GYRO_X_LOW;
		decAxis = relAddr[3:2];
		decHigh = relAddr[1];
		pageHit = (req.addr == ADDR_PAGE_SEL);
		gyroHit = (pageSel_r == PAGE_OUTPUT_DATA)
			&& (req.addr >= ADDR_GYRO_X_LOW)
			&& (req.addr <= ADDR_GYRO_Z_HIGH)
			&& !req.addr[0];
	end

	////////////////////////////////////////////////////////////////////////
	// Sample store, read through the target captured at the take
	// Whole-set writes keep both halves of a word pair from one sample
	gyod_sample_store #(
		.AXES(NUM_AXES)
	) u_store (
		.clk(clk),
		.reset(reset),
		.wrEn(sample.valid),
		.wrData(sample.rate),
		.rdAxis(rdAxis_r),
		.rdHigh(rdHigh_r),
		.rdData(storeData)
	);

	////////////////////////////////////////////////////////////////////////
	// Page selector: the only writable word, data words ignore writes
	// Any 16-bit value is kept; only page 0 maps the gyro words
	always_comb begin
		pageSel_nxt = pageSel_r;
		if (writeTake && pageHit) begin
			pageSel_nxt = req.wdata;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			pageSel_r <= PAGE_SEL_RESET;
		end else begin
			pageSel_r <= pageSel_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read sequencing: take, store lookup, answer
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			ST_IDLE: begin
				if (readTake) begin
					state_nxt = ST_READ;
				end
			end
			ST_READ: begin
				// Store registers the selected word in this cycle
				state_nxt = ST_ANSWER;
			end
			ST_ANSWER: begin
				// Port frees up as the answer goes out
				state_nxt = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state_r <= ST_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read target held from the take, so the host may drop the address
	always_comb begin
		rdAxis_nxt = rdAxis_r;
		rdHigh_nxt = rdHigh_r;
		pageRead_nxt = pageRead_r;
		gyroHit_nxt = gyroHit_r;
		if (readTake) begin
			rdAxis_nxt = decAxis;
			rdHigh_nxt = decHigh;
			pageRead_nxt = pageHit;
			gyroHit_nxt = gyroHit;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			rdAxis_r <= 2'h0;
			rdHigh_r <= 1'b0;
			pageRead_r <= 1'b0;
			gyroHit_r <= 1'b0;
		end else begin
			rdAxis_r <= rdAxis_nxt;
			rdHigh_r <= rdHigh_nxt;
			pageRead_r <= pageRead_nxt;
			gyroHit_r <= gyroHit_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Answer: one-cycle strobe, data held until the next answer
	always_comb begin
		rspValid_nxt = 1'b0;
		rspData_nxt = rspData_r;
		if (state_r == ST_ANSWER) begin
			rspValid_nxt = 1'b1;
			// Page selector reads back on every page
			if (pageRead_r) begin
				rspData_nxt = pageSel_r;
			end else if (gyroHit_r) begin
				rspData_nxt = storeData;
			end else begin
				rspData_nxt = UNMAPPED_READ;
			end
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			rspValid_r <= 1'b0;
			rspData_r <= WORD_RESET;
		end else begin
			rspValid_r <= rspValid_nxt;
			rspData_r <= rspData_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Sample strobe echo
	always_comb begin
		sampleSeen_nxt = sample.valid;
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			sampleSeen_r <= 1'b0;
		end else begin
			sampleSeen_r <= sampleSeen_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs straight from their registers
	assign rsp.valid = rspValid_r;
	assign rsp.data = rspData_r;
	assign activePage = pageSel_r;
	assign sampleSeen = sampleSeen_r;

endmodule : gyod_output_regs

/* gyod_pkg.sv */
// Package: register map, field layout and types of the gyro output data page
package gyod_pkg;

	localparam int ADDR_W = 7;
	localparam int WORD_W = 16;
	localparam int SAMPLE_W = 32;
	localparam int NUM_AXES = 3;
	localparam int PAGE_W = 16;

	localparam logic [ADDR_W-1:0] ADDR_PAGE_SEL = 7'h00;
	localparam logic [ADDR_W-1:0] ADDR_GYRO_X_LOW = 7'h10;
	localparam logic [ADDR_W-1:0] ADDR_GYRO_X_HIGH = 7'h12;
	localparam logic [ADDR_W-1:0] ADDR_GYRO_Y_LOW = 7'h14;
	localparam logic [ADDR_W-1:0] ADDR_GYRO_Y_HIGH = 7'h16;
	localparam logic [ADDR_W-1:0] ADDR_GYRO_Z_LOW = 7'h18;
	localparam logic [ADDR_W-1:0] ADDR_GYRO_Z_HIGH = 7'h1A;
	localparam logic [ADDR_W-1:0] AXIS_STRIDE = 7'h04;
	localparam logic [ADDR_W-1:0] HIGH_WORD_OFS = 7'h02;

	localparam logic [PAGE_W-1:0] PAGE_SEL_RESET = 16'h0000;
	localparam logic [PAGE_W-1:0] PAGE_OUTPUT_DATA = 16'h0000;
	localparam logic [WORD_W-1:0] UNMAPPED_READ = 16'h0000;
	localparam logic [SAMPLE_W-1:0] SAMPLE_RESET = 32'h0000_0000;
	localparam logic [WORD_W-1:0] WORD_RESET = 16'h0000;

	localparam int HIGH_MSB = 31;
	localparam int HIGH_LSB = 16;
	localparam int LOW_MSB = 15;
	localparam int LOW_LSB = 0;

	// Scaling, in milli-degrees per second; range in degrees per second
	localparam int HIGH_LSB_MDPS = 20;
	localparam int LOW_MSB_MDPS = 10;
	localparam int RANGE_DPS = 450;

	// One register access as seen by the serial port front end
	typedef struct packed {
		logic valid;
		logic write;
		logic [ADDR_W-1:0] addr;
		logic [WORD_W-1:0] wdata;
	} gyod_req_t;

	// One new gyro sample set, all three axes from the same instant
	typedef struct packed {
		logic valid;
		logic [NUM_AXES-1:0][SAMPLE_W-1:0] rate;
	} gyod_sample_t;

	typedef struct packed {
		logic valid;
		logic [WORD_W-1:0] data;
	} gyod_rsp_t;

endpackage : gyod_pkg

/* gyod_sample_store.sv */
// Sample store: holds the latest 32-bit rate per axis, read out by word
`timescale 1ns/1ps
module gyod_sample_store #(
	parameter int AXES = gyod_pkg::NUM_AXES
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic wrEn,
	input wire logic [AXES-1:0][gyod_pkg::SAMPLE_W-1:0] wrData,
	input wire logic [1:0] rdAxis,
	input wire logic rdHigh,
	output logic [gyod_pkg::WORD_W-1:0] rdData
);
	import gyod_pkg::*;

	logic [AXES-1:0][SAMPLE_W-1:0] mem_r;
	logic [AXES-1:0][SAMPLE_W-1:0] mem_nxt;
	logic [WORD_W-1:0] rdData_nxt;

	////////////////////////////////////////////////////////////////////////
	// Whole-set update so high and low words always belong together
	always_comb begin
		mem_nxt = mem_r;
		if (wrEn) begin
			mem_nxt = wrData;
		end
	end

	always_comb begin
		rdData_nxt = UNMAPPED_READ;
		if (32'(rdAxis) < AXES) begin
			if (rdHigh) begin
				rdData_nxt = mem_r[rdAxis][HIGH_MSB:HIGH_LSB];
			end else begin
				rdData_nxt = mem_r[rdAxis][LOW_MSB:LOW_LSB];
			end
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			mem_r <= '0;
			rdData <= WORD_RESET;
		end else begin
			mem_r <= mem_nxt;
			rdData <= rdData_nxt;
		end
	end

endmodule : gyod_sample_store

/* gyod_output_regs_assertions.sv */
// Checker: port timing and values of the gyro output page
`timescale 1ns/1ps
module gyod_output_regs_assertions (
	input wire logic clk,
	input wire logic reset,
	input gyod_pkg::gyod_req_t req,
	input gyod_pkg::gyod_sample_t sample,
	input gyod_pkg::gyod_rsp_t rsp,
	input wire logic [gyod_pkg::PAGE_W-1:0] activePage,
	input wire logic sampleSeen
);
	import gyod_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	wire logic rd = req.valid && !req.write;
	wire logic wp = req.valid && req.write && req.addr == ADDR_PAGE_SEL;
	wire logic gy = req.addr inside {[ADDR_GYRO_X_LOW:ADDR_GYRO_Z_HIGH]};
	property p_seen; sample.valid |=> sampleSeen; endproperty
	a_seen: assert property (p_seen) else $error("sample not seen");
	property p_cause; rsp.valid |-> $past(rd, 3); endproperty
	a_cause: assert property (p_cause) else $error("answer without read");
	property p_pulse; rsp.valid |=> !rsp.valid; endproperty
	a_pulse: assert property (p_pulse) else $error("answer too long");
	property p_hold; !rsp.valid |-> $stable(rsp.data); endproperty
	a_hold: assert property (p_hold) else $error("read data moved");
	property p_wr; wp |=> activePage == $past(req.wdata); endproperty
	a_wr: assert property (p_wr) else $error("page not written");
	property p_chg; $changed(activePage) |-> $past(wp); endproperty
	a_chg: assert property (p_chg) else $error("page changed alone");
	property p_odd; rd && req.addr[0] |-> ##3 rsp.data == UNMAPPED_READ; endproperty
	a_odd: assert property (p_odd) else $error("odd read not zero");
	property p_off; rd && gy && activePage != PAGE_OUTPUT_DATA |-> ##3 rsp.data == 16'h0000;
	endproperty
	a_off: assert property (p_off) else $error("gyro seen off page");
	c_rd: cover property (rsp.valid);
	c_wp: cover property (wp);
	c_smp: cover property (sample.valid);
endmodule : gyod_output_regs_assertions
bind gyod_output_regs gyod_output_regs_assertions chk (.clk(clk), .reset(reset), .req(req),
	.sample(sample), .rsp(rsp), .activePage(activePage), .sampleSeen(sampleSeen));

/* gyod_host_model.sv */
// Host model: master side register accesses
`timescale 1ns/1ps
module gyod_host_model (
	input wire logic clk,
	output gyod_pkg::gyod_req_t req,
	input gyod_pkg::gyod_rsp_t rsp
);
	import gyod_pkg::*;
	initial req = '0;
	// Any single word may be read alone
	task automatic acc(input logic w, input logic [ADDR_W-1:0] a,
		input logic [WORD_W-1:0] d, output logic [WORD_W-1:0] q);
		@(negedge clk);
		req = '{1'b1, w, a, d};
		@(negedge clk);
		// Released fields flip so stale values are never trusted
		req = '{1'b0, w, ~a, ~d};
		q = 'x;
		for (int n = 0; n < 4 && !w; n++) begin
			@(negedge clk);
			if (rsp.valid === 1'b1) q = rsp.data;
		end
	endtask : acc
endmodule : gyod_host_model

/* gyod_output_regs_tb.sv */
// Testbench: gyro output page
`timescale 1ns/1ps
module gyod_output_regs_tb;
	import gyod_pkg::*;
	logic clk;
	logic reset;
	gyod_req_t req;
	gyod_sample_t sample;
	gyod_rsp_t rsp;
	logic [PAGE_W-1:0] activePage;
	logic sampleSeen;
	logic [WORD_W-1:0] q;
	int fail_count;
	int cmp_count;
	int cyc;
	gyod_output_regs dut (.clk(clk), .reset(reset), .req(req), .sample(sample), .rsp(rsp),
		.activePage(activePage), .sampleSeen(sampleSeen));
	gyod_host_model host (.clk(clk), .req(req), .rsp(rsp));
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	always @(posedge clk) if (++cyc > 3000) begin
		fail_count++;
		wrap_up();
	end
	task automatic wrap_up();
		if (fail_count == 0 && cmp_count > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : wrap_up
	task automatic chk(input string nm, input logic [WORD_W-1:0] e, input logic [WORD_W-1:0] s);
		cmp_count++;
		if (s !== e) begin
			fail_count++;
			$display("[ERR] %s exp %h got %h", nm, e, s);
		end
	endtask : chk
	task automatic rd(input logic [ADDR_W-1:0] a, input logic [WORD_W-1:0] e, input string nm);
		host.acc(1'b0, a, 16'h0000, q);
		chk(nm, e, q);
	endtask : rd
	task automatic load(input logic [SAMPLE_W-1:0] x, y, z);
		@(negedge clk);
		sample = '{1'b1, {z, y, x}};
		@(negedge clk);
		sample.valid = 1'b0;
		chk("sampleSeen", 16'h0001, {15'h0000, sampleSeen});
	endtask : load
	task automatic t_reset();
		chk("activePage", 16'h0000, activePage);
		rd(ADDR_PAGE_SEL, 16'h0000, "pageRd");
		rd(ADDR_GYRO_X_HIGH, 16'h0000, "xRest");
	endtask : t_reset
	task automatic t_words();
		logic [SAMPLE_W-1:0] v [3] = '{32'h57E4_8000, 32'hA81C_0001, 32'hFFFF_FFFF};
		load(v[0], v[1], v[2]);
		for (int i = 0; i < 3; i++) begin
			host.acc(1'b1, ADDR_GYRO_X_HIGH + 7'(i * 4), 16'h1234, q);
			rd(ADDR_GYRO_X_LOW + 7'(i * 4), v[i][15:0], "low");
			rd(ADDR_GYRO_X_HIGH + 7'(i * 4), v[i][31:16], "high");
		end
	endtask : t_words
	task automatic t_page();
		host.acc(1'b1, ADDR_PAGE_SEL, 16'h0003, q);
		chk("activePage", 16'h0003, activePage);
		rd(ADDR_GYRO_Z_HIGH, 16'h0000, "offPage");
		rd(ADDR_PAGE_SEL, 16'h0003, "pageRd");
		host.acc(1'b1, ADDR_PAGE_SEL, 16'h0000, q);
		rd(ADDR_GYRO_Z_HIGH, 16'hFFFF, "onPage");
		rd(7'h13, 16'h0000, "oddAddr");
	endtask : t_page
	task automatic t_pair();
		rd(ADDR_GYRO_Y_LOW, 16'h0001, "yLowOld");
		load(32'h0000_0000, 32'h0123_4567, 32'h0000_0000);
		rd(ADDR_GYRO_Y_HIGH, 16'h0123, "yHighNew");
		rd(ADDR_GYRO_Y_LOW, 16'h4567, "yLowNew");
	endtask : t_pair
	task automatic t_rerun();
		host.acc(1'b1, ADDR_PAGE_SEL, 16'h0005, q);
		load(32'h1111_2222, 32'h3333_4444, 32'h5555_6666);
		@(negedge clk);
		reset = 1'b1;
		repeat (3) @(negedge clk);
		reset = 1'b0;
		chk("activePage", 16'h0000, activePage);
		rd(ADDR_PAGE_SEL, 16'h0000, "pageRst");
		rd(ADDR_GYRO_X_HIGH, 16'h0000, "xRst");
	endtask : t_rerun
	initial begin
		sample = '0;
		reset = 1'b1;
		repeat (10) @(negedge clk);
		reset = 1'b0;
		t_reset();
		t_words();
		t_page();
		t_pair();
		t_rerun();
		wrap_up();
	end
endmodule : gyod_output_regs_tb
